// ---- design/tcpu_top.sv ----
// Purpose: 16-bit timer/counter/PWM unit with capture, dead band and kill
// Assumes: Configuration arrives on plain ports, synchronous to i_mclk
// Notes on behaviour
// RL1: A 16-bit counter runs with a firmware-set period value.
// RL2: A capture event, possibly from a pin, copies the counter into capture.
// RL3: At count equal to period, counter halts or reloads per configuration.
// RL4: Counter is compared with compare value; the match forms the PWM duty.
// RL5: True and complementary outputs with programmable dead-band offset.
// RL6: Kill input forces outputs to a safe state immediately.
// RL7: Counter advances one per clock while running; matches use that clock.
`timescale 1ns/10ps
`default_nettype none
`include "tcpu_map.svh"
module tcpu_top
    import tcpu_pkg::*;
#(
    parameter int CNT_W = `TCPU_CNT_W,
    parameter int DT_W = `TCPU_DT_W
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire tcpu_ctrl_t i_ctrl,
    input wire logic [CNT_W-1:0] i_period,
    input wire logic [CNT_W-1:0] i_compare,
    input wire logic [DT_W-1:0] i_dead,
    input wire logic i_capture_pin,
    input wire logic i_kill,
    output logic [CNT_W-1:0] o_count,
    output logic [CNT_W-1:0] o_capture,
    output logic o_capture_pulse,
    output logic o_period_pulse,
    output logic o_halted,
    output logic o_pwm_true,
    output logic o_pwm_comp
);
    // ==========================================================
    // Checks
    initial begin
        if (CNT_W != 16) $error("tcpu_top: counter must be 16 bits");
        if (DT_W < 1 || DT_W > 16) $error("tcpu_top: DT_W out of range");
    end

    // ==========================================================
    // Counter state machine
    tcpu_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic per_q, per_d;
    logic per_hit;

    assign per_hit = (st_q == TCPU_RUN) && (cnt_q == i_period); // RL3

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        per_d = 1'b0;
        case (st_q)
            TCPU_IDLE: begin
                cnt_d = `TCPU_CNT_RST;
                if (i_ctrl.run) begin
                    st_d = TCPU_RUN;
                end
            end
            TCPU_RUN: begin
                if (!i_ctrl.run) begin
                    st_d = TCPU_IDLE;
                end else if (per_hit) begin
                    per_d = 1'b1;
                    if (i_ctrl.one_shot) begin
                        st_d = TCPU_HALT; // RL3
                    end else begin
                        cnt_d = `TCPU_CNT_RST; // RL3
                    end
                end else begin
                    cnt_d = cnt_q + 1'b1; // RL1 RL7
                end
            end
            TCPU_HALT: begin
                // Held at period until run drops, then restarts from zero
                if (!i_ctrl.run) begin
                    st_d = TCPU_IDLE;
                end
            end
            default: begin
                st_d = TCPU_IDLE;
                cnt_d = `TCPU_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_q <= TCPU_IDLE;
            cnt_q <= `TCPU_CNT_RST;
            per_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
        end
    end

    // ==========================================================
    // Capture on selected pin edge
    logic pin_last_q, pin_last_d;
    logic [CNT_W-1:0] cap_q, cap_d;
    logic cap_p_q, cap_p_d;
    logic cap_evt;

    assign cap_evt = i_ctrl.capture_edge_fall ? (pin_last_q && !i_capture_pin)
                                              : (!pin_last_q && i_capture_pin);

    always_comb begin
        pin_last_d = i_capture_pin;
        cap_d = cap_q;
        cap_p_d = 1'b0;
        if (cap_evt) begin
            cap_d = cnt_q; // RL2
            cap_p_d = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_last_q <= 1'b0;
            cap_q <= '0;
            cap_p_q <= 1'b0;
        end else begin
            pin_last_q <= pin_last_d;
            cap_q <= cap_d;
            cap_p_q <= cap_p_d;
        end
    end

    // ==========================================================
    // PWM compare
    logic pwm_q, pwm_d;

    always_comb begin
        // High while count is below compare; compare of zero gives 0 % duty
        // Next state, so the first count after start already sets the leg
        pwm_d = (st_d != TCPU_IDLE) && (cnt_d < i_compare); // RL4 RL7
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= pwm_d;
        end
    end

    tcpu_drive_t drive;

    tcpu_deadband #(
        .DT_W(DT_W)
    ) u_deadband (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pwm(pwm_q),
        .i_dead(i_dead),
        .o_drive(drive)
    );

    // ==========================================================
    // Outputs; kill is combinational so no clock edge is waited for
    assign o_pwm_true = i_kill ? `TCPU_SAFE_TRUE : drive.pwm_true; // RL6
    assign o_pwm_comp = i_kill ? `TCPU_SAFE_COMP : drive.pwm_comp; // RL6
    assign o_count = cnt_q;
    assign o_capture = cap_q;
    assign o_capture_pulse = cap_p_q;
    assign o_period_pulse = per_q;
    assign o_halted = (st_q == TCPU_HALT);

    // ==========================================================
    // Checks on behaviour
    sequence s_hit_reload;
        per_hit && i_ctrl.run && !i_ctrl.one_shot;
    endsequence

    AST_KILL_SAFE: assert property (@(posedge i_mclk) disable iff (i_rst) // RL6
        i_kill |-> (o_pwm_true == `TCPU_SAFE_TRUE) && (o_pwm_comp == `TCPU_SAFE_COMP))
        else $error("kill did not force safe outputs");

    AST_COUNT_STEP: assert property (@(posedge i_mclk) disable iff (i_rst) // RL7
        (st_q == TCPU_RUN && i_ctrl.run && !per_hit) |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("counter did not advance by one");

    AST_RELOAD: assert property (@(posedge i_mclk) disable iff (i_rst) // RL3
        s_hit_reload |=> (cnt_q == `TCPU_CNT_RST) && per_q)
        else $error("counter did not reload at period");

    AST_HALT: assert property (@(posedge i_mclk) disable iff (i_rst) // RL3
        (per_hit && i_ctrl.run && i_ctrl.one_shot) |=> o_halted && cnt_q == $past(cnt_q))
        else $error("one-shot did not halt at period");

    AST_NO_PASS: assert property (@(posedge i_mclk) disable iff (i_rst) // RL1
        (st_q == TCPU_RUN && cnt_q <= i_period && $stable(i_period)) |=> cnt_q <= $past(i_period))
        else $error("counter passed period");

    AST_CAPTURE: assert property (@(posedge i_mclk) disable iff (i_rst) // RL2
        cap_evt |=> o_capture == $past(cnt_q) && o_capture_pulse)
        else $error("capture value wrong");

    AST_PWM_DUTY: assert property (@(posedge i_mclk) disable iff (i_rst) // RL4
        (st_q == TCPU_RUN && cnt_q < i_compare && $stable(i_compare)) |-> pwm_q)
        else $error("pwm low below compare");

    AST_PWM_OFF: assert property (@(posedge i_mclk) disable iff (i_rst) // RL4
        (st_q == TCPU_RUN && cnt_q >= i_compare && $stable(i_compare)) |-> !pwm_q)
        else $error("pwm high at or above compare");

    AST_CAP_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst) // RL2
        !cap_evt |=> $stable(o_capture) && !o_capture_pulse)
        else $error("capture changed without an event");

    // Halted count must hold until run is dropped
    AST_HALT_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst) // RL3
        (o_halted && i_ctrl.run) |=> o_halted && $stable(o_count))
        else $error("halted counter moved");

    AST_IDLE_LOW: assert property (@(posedge i_mclk) disable iff (i_rst) // RL4
        (st_q == TCPU_IDLE) [*2] |-> !pwm_q)
        else $error("pwm active while idle");
endmodule
`default_nettype wire

// ---- design/tcpu_map.svh ----
// Purpose: Constants for the timer/counter/PWM unit
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef TCPU_MAP_SVH
`define TCPU_MAP_SVH
`define TCPU_CNT_W 16
`define TCPU_CNT_RST 16'h0000
`define TCPU_DT_W 8
`define TCPU_SAFE_TRUE 1'b0
`define TCPU_SAFE_COMP 1'b0
`endif

// ---- design/tcpu_pkg.sv ----
// Purpose: Types for the timer/counter/PWM unit
// Assumes: 16-bit counter
// Notes: Constants live in tcpu_map.svh
package tcpu_pkg;
    typedef enum logic [2:0] {
        TCPU_IDLE = 3'b001,
        TCPU_RUN = 3'b010,
        TCPU_HALT = 3'b100
    } tcpu_state_t;
    typedef struct packed {
        logic run;
        logic one_shot;
        logic capture_edge_fall;
    } tcpu_ctrl_t;
    typedef struct packed {
        logic pwm_true;
        logic pwm_comp;
    } tcpu_drive_t;
endpackage

// ---- design/tcpu_deadband.sv ----
// Purpose: Dead-band generator for true/complementary outputs
// Assumes: Delay counted in clock cycles
// Notes: Each rising edge of a leg is delayed, falling edges are immediate
`timescale 1ns/10ps
`default_nettype none
`include "tcpu_map.svh"
module tcpu_deadband
    import tcpu_pkg::*;
#(
    parameter int DT_W = `TCPU_DT_W
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_pwm,
    input wire logic [DT_W-1:0] i_dead,
    output tcpu_drive_t o_drive
);
    logic [DT_W-1:0] cnt_q, cnt_d;
    logic last_q, last_d;
    tcpu_drive_t drv_q, drv_d;

    initial begin
        if (DT_W < 1 || DT_W > 16) $error("tcpu_deadband: DT_W out of range");
    end

    always_comb begin
        cnt_d = cnt_q;
        last_d = i_pwm;
        drv_d = drv_q;
        if (i_pwm != last_q) begin
            // Both legs off first, the new leg waits out the dead time
            cnt_d = i_dead;
            drv_d.pwm_true = 1'b0;
            drv_d.pwm_comp = 1'b0;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end else begin
            drv_d.pwm_true = last_q; // RL5
            drv_d.pwm_comp = ~last_q; // RL5
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_q <= '0;
            last_q <= 1'b0;
            drv_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            last_q <= last_d;
            drv_q <= drv_d;
        end
    end

    assign o_drive = drv_q;

    // Never both legs on at once
    AST_NO_OVERLAP: assert property (@(posedge i_mclk) disable iff (i_rst) // RL5
        !(drv_q.pwm_true && drv_q.pwm_comp))
        else $error("true and complementary legs on together");
endmodule
`default_nettype wire

// ---- dv/tcpu_switch_model.sv ----
// Purpose: Model of the power switches and the event pin
// Assumes: Legs sampled on each rising i_mclk edge
// Notes: Counts shoot-through and dead gaps shorter than i_dead
`timescale 1ns/10ps
`default_nettype none
module tcpu_switch_model (
    input wire logic i_mclk,
    input wire logic i_true,
    input wire logic i_comp,
    input wire logic [7:0] i_dead,
    output logic o_pin,
    output int o_bad,
    output int o_highs
);
    int gap = 0;
    initial o_pin = 1'b0;
    initial o_bad = 0;
    initial o_highs = 0;
    // ==========
    // Both legs on would short the supply
    always @(posedge i_mclk) begin
        if (i_true === 1'b1 && i_comp === 1'b1) o_bad++;
        if ((i_true || i_comp) && gap > 0 && gap < int'(i_dead)) o_bad++;
        gap = (i_true || i_comp) ? 0 : gap + 1;
        if (i_true === 1'b1) o_highs++;
    end
    // ==========
    // Event pin: one-cycle pulse after n falling edges
    task automatic pulse(input int n);
        repeat (n) @(negedge i_mclk);
        o_pin = 1'b1;
        @(negedge i_mclk);
        o_pin = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for tcpu_top
// Assumes: Driver queues notes, monitor pops them
// Notes: Intervals are compared, so fixed latencies cancel out
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tcpu_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    tcpu_ctrl_t i_ctrl = '0;
    logic [15:0] i_period = 16'h0000;
    logic [15:0] i_compare = 16'h0000;
    logic [7:0] i_dead = 8'h00;
    logic i_kill = 1'b0;
    logic pin, o_capture_pulse, o_period_pulse, o_halted, o_pwm_true, o_pwm_comp;
    logic [15:0] o_count, o_capture, last_cap;
    logic was_h = 1'b0;
    logic [31:0] seed = 32'h0000_0033;
    int err_total = 0;
    int n_compared = 0;
    int bad, highs, n, m, p, h0, cyc = 0, last_per = 0;
    int per_q[$];
    int cap_q[$];
    logic [15:0] hal_q[$];
    always #5 i_mclk = ~i_mclk;
    tcpu_top tcpu_top_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_ctrl(i_ctrl),
        .i_period(i_period), .i_compare(i_compare), .i_dead(i_dead),
        .i_capture_pin(pin), .i_kill(i_kill), .o_count(o_count), .o_capture(o_capture),
        .o_capture_pulse(o_capture_pulse), .o_period_pulse(o_period_pulse),
        .o_halted(o_halted), .o_pwm_true(o_pwm_true), .o_pwm_comp(o_pwm_comp));
    tcpu_switch_model tcpu_switch_model_i (.i_mclk(i_mclk), .i_true(o_pwm_true),
        .i_comp(o_pwm_comp), .i_dead(i_dead), .o_pin(pin), .o_bad(bad), .o_highs(highs));
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed & 32'h0000_ffff);
    endfunction
    task automatic chk_n(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            err_total++;
            $display("[FAIL] %0t count %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========
    // Monitor: outputs settle by the falling edge
    always @(negedge i_mclk) begin
        cyc++;
        if (o_period_pulse === 1'b1 && per_q.size() > 0) begin
            m = per_q.pop_front();
            if (m >= 0) chk_n(cyc - last_per, m);
            last_per = cyc;
        end
        if (o_capture_pulse === 1'b1 && cap_q.size() > 0) begin
            m = cap_q.pop_front();
            if (m >= 0) chk_v(o_capture - last_cap, 16'(m));
            last_cap = o_capture;
        end
        if (o_halted === 1'b1 && !was_h && hal_q.size() > 0) chk_v(o_count, hal_q.pop_front());
        was_h = o_halted;
    end
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
    // ==========
    // Driver
    initial begin
        i_dead = 8'(1 + rnd() % 4);
        repeat (10) @(negedge i_mclk);
        chk_v(o_count, 16'h0000);
        i_rst = 1'b0;
        for (int r = 0; r < 4; r++) begin
            p = 8 + rnd() % 16;
            i_period = 16'(p);
            i_compare = (r == 0) ? 16'h0000 : 16'(6 + rnd() % (p - 5));
            i_ctrl.one_shot = (r == 3);
            if (r == 3) hal_q.push_back(16'(p));
            else per_q = '{-1, p + 1, p + 1, p + 1};
            h0 = highs;
            i_ctrl.run = 1'b1;
            repeat (4 * (p + 1) + 3) @(negedge i_mclk);
            chk_n(per_q.size() + hal_q.size(), 0);
            chk_n(highs > h0, r != 0);
            i_ctrl.run = 1'b0;
            repeat (3) @(negedge i_mclk);
            $display("period run %0d done", r);
        end
        i_period = 16'hffff;
        i_ctrl.run = 1'b1;
        for (int e = 0; e < 2; e++) begin
            i_ctrl.capture_edge_fall = e[0];
            cap_q.push_back(-1);
            tcpu_switch_model_i.pulse(2);
            for (int k = 0; k < 3; k++) begin
                n = 1 + rnd() % 6;
                cap_q.push_back(n + 1);
                tcpu_switch_model_i.pulse(n);
            end
            repeat (4) @(negedge i_mclk);
            chk_n(cap_q.size(), 0);
        end
        $display("capture test done");
        i_compare = 16'hffff;
        repeat (20) @(negedge i_mclk);
        chk_v({15'h0000, o_pwm_true}, 16'h0001);
        chk_n(bad, 0);
        i_kill = 1'b1;
        #1;
        chk_v({14'h0000, o_pwm_true, o_pwm_comp}, 16'h0000);
        repeat (6) @(negedge i_mclk);
        chk_v({14'h0000, o_pwm_true, o_pwm_comp}, 16'h0000);
        i_kill = 1'b0;
        #1;
        chk_v({14'h0000, o_pwm_true, o_pwm_comp}, 16'h0002);
        $display("kill test done");
        print_verdict();
    end
endmodule
`default_nettype wire
